// ### core/unvm_decrypt.sv
`include "unvm_consts.svh"

// Keyed line unscrambler standing in for the on-chip block decryptor.
// It takes a full bank line and returns the plain line a fixed number of cycles later.
module unvm_decrypt (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Line in.
    input wire logic start,
    input wire unvm_pkg::unvm_line_t key,
    input wire unvm_pkg::unvm_line_t cipher,
    // Line out.
    output logic done,
    output unvm_pkg::unvm_line_t plain
);
    logic [1:0] round_reg;
    logic busy_reg;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            round_reg <= 2'h0;
            busy_reg <= 1'b0;
            done <= 1'b0;
            plain <= `UNVM_KEY_RST;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy_reg <= 1'b1;
                round_reg <= 2'h0;
                plain <= cipher ^ key;
            end else if (busy_reg) begin
                plain <= {plain[119:0], plain[127:120]} ^ key;
                round_reg <= round_reg + 2'h1;
                if (round_reg == 2'h3) begin
                    busy_reg <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // unvm_decrypt

// ### core/unvm_top.sv
`include "unvm_consts.svh"

module unvm_top (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Core read port.
    input wire logic core_rd_en,
    input wire unvm_pkg::unvm_addr_t core_addr,
    output unvm_pkg::unvm_byte_t core_rd_data,
    // Programming port bank write.
    input wire logic prog_wr_en,
    input wire unvm_pkg::unvm_bank_t prog_bank,
    input wire unvm_pkg::unvm_line_t prog_line,
    input wire logic prog_encrypted,
    output logic prog_busy,
    output logic prog_done,
    // Programming port key load.
    input wire logic prog_key_wr,
    input wire unvm_pkg::unvm_line_t prog_key,
    // Programming port readback.
    input wire logic prog_rd_en,
    input wire unvm_pkg::unvm_bank_t prog_rd_bank,
    output unvm_pkg::unvm_line_t prog_rd_line,
    output logic prog_rd_valid
);
    unvm_pkg::unvm_byte_t mem [`UNVM_DEPTH];
    unvm_pkg::unvm_prog_state_e state_reg;
    unvm_pkg::unvm_bank_t bank_reg;
    unvm_pkg::unvm_line_t line_reg;
    unvm_pkg::unvm_line_t key_reg;
    logic dec_start_reg;
    logic dec_done;
    unvm_pkg::unvm_line_t dec_plain;

    // Flat byte index of a bank and byte position.
    function automatic logic [6:0] flat_idx(input logic [2:0] bank, input logic [3:0] idx);
        flat_idx = {bank, idx};
    endfunction

    unvm_decrypt u_dec (
        .clock(clock),
        .sys_rst(sys_rst),
        .start(dec_start_reg),
        .key(key_reg),
        .cipher(line_reg),
        .done(dec_done),
        .plain(dec_plain)
    );

    // Key register is loaded only from the programming side.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            key_reg <= `UNVM_KEY_RST;
        end else if (prog_key_wr && state_reg == unvm_pkg::UNVM_IDLE) begin
            key_reg <= prog_key;
        end
    end

    // Programming sequencer.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= unvm_pkg::UNVM_IDLE;
            bank_reg <= 3'h0;
            line_reg <= `UNVM_KEY_RST;
            dec_start_reg <= 1'b0;
            prog_busy <= 1'b0;
            prog_done <= 1'b0;
        end else begin
            dec_start_reg <= 1'b0;
            prog_done <= 1'b0;
            case (state_reg)
                unvm_pkg::UNVM_IDLE: begin
                    if (prog_wr_en) begin
                        bank_reg <= prog_bank;
                        line_reg <= prog_line;
                        prog_busy <= 1'b1;
                        if (prog_encrypted) begin
                            dec_start_reg <= 1'b1;
                            state_reg <= unvm_pkg::UNVM_DECRYPT;
                        end else begin
                            state_reg <= unvm_pkg::UNVM_STORE;
                        end
                    end
                end
                unvm_pkg::UNVM_DECRYPT: begin
                    if (dec_done) begin
                        line_reg <= dec_plain;
                        state_reg <= unvm_pkg::UNVM_STORE;
                    end
                end
                unvm_pkg::UNVM_STORE: begin
                    prog_busy <= 1'b0;
                    prog_done <= 1'b1;
                    state_reg <= unvm_pkg::UNVM_IDLE;
                end
                default: begin
                    state_reg <= unvm_pkg::UNVM_IDLE;
                    prog_busy <= 1'b0;
                end
            endcase
        end
    end

    // The array is written only here, from the programming sequencer.
    always_ff @(posedge clock) begin
        if (state_reg == unvm_pkg::UNVM_STORE) begin
            for (int i = 0; i < `UNVM_BYTES_PER_BANK; i++) begin
                mem[flat_idx(bank_reg, 4'(i))] <= line_reg[8*i +: 8];
            end
        end
    end

    // Core byte read port.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            core_rd_data <= `UNVM_DATA_RST;
        end else if (core_rd_en) begin
            core_rd_data <= mem[flat_idx(core_addr[`UNVM_BANK_MSB:`UNVM_BANK_LSB],
                core_addr[`UNVM_BYTE_MSB:`UNVM_BYTE_LSB])];
        end
    end

    // Programming side readback of a whole bank.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prog_rd_line <= `UNVM_KEY_RST;
            prog_rd_valid <= 1'b0;
        end else begin
            prog_rd_valid <= prog_rd_en;
            if (prog_rd_en) begin
                for (int i = 0; i < `UNVM_BYTES_PER_BANK; i++) begin
                    prog_rd_line[8*i +: 8] <= mem[flat_idx(prog_rd_bank, 4'(i))];
                end
            end
        end
    end

    // Checks.
    property p_core_read;
        @(posedge clock) disable iff (sys_rst)
        core_rd_en |=> core_rd_data == $past(mem[core_addr]);
    endproperty
    a_core_read: assert property (p_core_read) else $error("core byte wrong");

    property p_hold;
        @(posedge clock) disable iff (sys_rst)
        !core_rd_en |=> $stable(core_rd_data);
    endproperty
    a_hold: assert property (p_hold) else $error("core byte not held");

    property p_bank_sel;
        @(posedge clock) disable iff (sys_rst)
        core_rd_en |=> core_rd_data == mem[{$past(core_addr[6:4]), $past(core_addr[3:0])}];
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("bank decode wrong");

    property p_byte_sel;
        @(posedge clock) disable iff (sys_rst)
        core_rd_en && core_addr[3:0] == 4'h0
            |=> core_rd_data == mem[{$past(core_addr[6:4]), 4'h0}];
    endproperty
    a_byte_sel: assert property (p_byte_sel) else $error("byte decode wrong");

    property p_plain_store;
        @(posedge clock) disable iff (sys_rst)
        state_reg == unvm_pkg::UNVM_IDLE && prog_wr_en && !prog_encrypted
            |=> ##1 prog_done ##0 mem[{bank_reg, 4'h0}] == line_reg[7:0];
    endproperty
    a_plain_store: assert property (p_plain_store) else $error("bank store wrong");

    property p_no_core_write;
        @(posedge clock) disable iff (sys_rst)
        state_reg != unvm_pkg::UNVM_STORE
            |=> mem[$past(core_addr)] === $past(mem[core_addr]);
    endproperty
    a_no_core_write: assert property (p_no_core_write) else $error("store changed");

    property p_readback;
        @(posedge clock) disable iff (sys_rst)
        prog_rd_en |=> prog_rd_valid && prog_rd_line[7:0] == mem[{$past(prog_rd_bank), 4'h0}];
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");

    property p_decrypt_time;
        @(posedge clock) disable iff (sys_rst)
        state_reg == unvm_pkg::UNVM_IDLE && prog_wr_en && prog_encrypted
            |=> prog_busy ##7 prog_done;
    endproperty
    a_decrypt_time: assert property (p_decrypt_time) else $error("decrypt path late");

    property p_addr_width;
        @(posedge clock) disable iff (sys_rst)
        core_rd_en |=> core_rd_data == mem[$past(core_addr) & 7'h7f];
    endproperty
    a_addr_width: assert property (p_addr_width) else $error("address range wrong");

    // A write request that arrives while the sequencer is busy must not retarget the bank.
    property p_refuse_busy;
        @(posedge clock) disable iff (sys_rst)
        prog_busy && prog_wr_en |=> $stable(bank_reg);
    endproperty
    a_refuse_busy: assert property (p_refuse_busy) else $error("busy write taken");

    property p_done_idle;
        @(posedge clock) disable iff (sys_rst)
        prog_done |-> !prog_busy && state_reg == unvm_pkg::UNVM_IDLE;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done while busy");

    c_read: cover property (@(posedge clock) disable iff (sys_rst) core_rd_en ##1 core_rd_en);
    c_plain: cover property (@(posedge clock) disable iff (sys_rst) prog_done && !prog_encrypted);
    c_enc: cover property (@(posedge clock) disable iff (sys_rst) state_reg == unvm_pkg::UNVM_DECRYPT ##[1:6] prog_done);
    c_rb: cover property (@(posedge clock) disable iff (sys_rst) prog_rd_valid);
endmodule // unvm_top

// ### pkg/unvm_consts.svh
`ifndef UNVM_CONSTS_SVH
`define UNVM_CONSTS_SVH

// Store organisation.
`define UNVM_BANKS 8
`define UNVM_BANK_BITS 128
`define UNVM_BYTES_PER_BANK 16
`define UNVM_ADDR_W 7
`define UNVM_BANK_MSB 6
`define UNVM_BANK_LSB 4
`define UNVM_BYTE_MSB 3
`define UNVM_BYTE_LSB 0
`define UNVM_DEPTH 128

// Reset values.
`define UNVM_DATA_RST 8'h00
`define UNVM_KEY_RST 128'h0

`endif

// ### pkg/unvm_pkg.sv
package unvm_pkg;
    typedef logic [7:0] unvm_byte_t;
    typedef logic [6:0] unvm_addr_t;
    typedef logic [2:0] unvm_bank_t;
    typedef logic [3:0] unvm_idx_t;
    typedef logic [127:0] unvm_line_t;

    // Programming port sequencer states.
    typedef enum logic [1:0] {
        UNVM_IDLE = 2'b00,
        UNVM_DECRYPT = 2'b01,
        UNVM_STORE = 2'b10
    } unvm_prog_state_e;
endpackage

// ### test/unvm_core_user.sv
// Core-side reader standing in for user logic that fetches bytes.
module unvm_core_user (
    // Clock.
    input wire logic clock,
    // Requests from the bench.
    input wire logic req,
    input wire unvm_pkg::unvm_addr_t req_addr,
    // Core read port.
    output logic core_rd_en,
    output unvm_pkg::unvm_addr_t core_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    // Between reads the address toggles so a stale address never looks held.
    always @(posedge clock) begin
        core_rd_en <= req;
        core_addr <= req ? req_addr : ~core_addr;
    end
endmodule // unvm_core_user

// ### test/unvm_top_tb_top.sv
module unvm_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, sys_rst, core_rd_en, prog_wr_en, prog_encrypted, prog_busy, prog_done;
    logic prog_key_wr, prog_rd_en, prog_rd_valid, req;
    unvm_pkg::unvm_addr_t core_addr, req_addr;
    unvm_pkg::unvm_byte_t core_rd_data;
    unvm_pkg::unvm_bank_t prog_bank, prog_rd_bank;
    unvm_pkg::unvm_line_t prog_line, prog_key, prog_rd_line;
    int unsigned mem_model[128];
    int mismatches, checked, rd_addr;
    logic [7:0] last_exp;

    always #10 clock = ~clock;

    unvm_top unvm_top_inst (.clock(clock), .sys_rst(sys_rst), .core_rd_en(core_rd_en),
        .core_addr(core_addr), .core_rd_data(core_rd_data), .prog_wr_en(prog_wr_en),
        .prog_bank(prog_bank), .prog_line(prog_line), .prog_encrypted(prog_encrypted),
        .prog_busy(prog_busy), .prog_done(prog_done), .prog_key_wr(prog_key_wr),
        .prog_key(prog_key), .prog_rd_en(prog_rd_en), .prog_rd_bank(prog_rd_bank),
        .prog_rd_line(prog_rd_line), .prog_rd_valid(prog_rd_valid));
    unvm_core_user unvm_core_user_inst (.clock(clock), .req(req), .req_addr(req_addr),
        .core_rd_en(core_rd_en), .core_addr(core_addr));

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d, mismatched %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic unvm_pkg::unvm_line_t unscramble(input unvm_pkg::unvm_line_t c, k);
        unvm_pkg::unvm_line_t p;
        p = c ^ k;
        for (int r = 0; r < 4; r++) begin
            p = {p[119:0], p[127:120]} ^ k;
        end
        return p;
    endfunction

    // While an encrypted write is busy a second request aimed at another bank is sent.
    task automatic write_bank(input int b, input bit enc);
        unvm_pkg::unvm_line_t line, plain;
        int n;
        line = {$urandom, $urandom, $urandom, $urandom};
        plain = enc ? unscramble(line, prog_key) : line;
        @(posedge clock);
        prog_wr_en <= 1'b1;
        prog_bank <= b[2:0];
        prog_line <= line;
        prog_encrypted <= enc;
        n = 0;
        do begin
            @(posedge clock);
            prog_wr_en <= enc && n == 2;
            prog_bank <= b[2:0] ^ {2'h0, enc && n == 2};
            #1;
            n++;
            if (n == 1) check(prog_busy, 1'b1);
        end while (prog_done !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            complete_run();
        end
        check(n, enc ? 8 : 2);
        for (int i = 0; i < 16; i++) mem_model[b * 16 + i] = plain[8 * i +: 8];
    endtask

    task automatic read_bank(input int b);
        @(posedge clock);
        prog_rd_en <= 1'b1;
        prog_rd_bank <= b[2:0];
        @(posedge clock);
        prog_rd_en <= 1'b0;
        #1;
        check(prog_rd_valid, 1'b1);
        for (int i = 0; i < 16; i++) check(prog_rd_line[8 * i +: 8], mem_model[b * 16 + i]);
    endtask

    always @(posedge clock) begin
        if (sys_rst === 1'b0 && core_rd_en === 1'b1) begin
            rd_addr = core_addr;
            last_exp = mem_model[rd_addr][7:0];
            #1;
            check(core_rd_data, last_exp);
        end
    end

    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        {req, prog_wr_en, prog_encrypted, prog_key_wr, prog_rd_en} = 5'h00;
        {req_addr, prog_bank, prog_rd_bank, prog_line, prog_key} = '0;
        mismatches = 0;
        checked = 0;
        void'($urandom(32));
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        check({prog_busy, prog_done, prog_rd_valid, core_rd_data}, 11'h000);
        @(posedge clock);
        prog_key_wr <= 1'b1;
        prog_key <= {$urandom, $urandom, $urandom, $urandom};
        @(posedge clock);
        prog_key_wr <= 1'b0;
        for (int b = 0; b < 8; b++) write_bank(b, b[0]);
        for (int b = 0; b < 8; b++) read_bank(b);
        $display("test program and readback done");
        for (int k = 0; k < 192; k++) begin
            @(posedge clock);
            req <= k % 9 != 8;
            req_addr <= k < 128 ? k[6:0] : 7'($urandom);
        end
        @(posedge clock);
        req <= 1'b0;
        repeat (5) @(posedge clock);
        #1;
        check(core_rd_data, last_exp);
        $display("test core reads done");
        for (int b = 0; b < 8; b++) read_bank(b);
        $display("test store unchanged done");
        complete_run();
    end
endmodule // unvm_top_tb_top
